// >>> dtec_top.sv
// Dual 16-bit timer/event counter with APB register access.
// Assumes count and gating pins are asynchronous; APB on pclk.
// What this block does
// RQ1: Two independently configured timer/counters, each a timer or event counter.
// RQ2: The low byte cascades into the high byte to form a 16-bit counter.
// RQ3: Low overflow bumps the high byte; high overflow sets the overflow flag and interrupt.
// RQ4: Counting proceeds only while the run bit is set.
// RQ5: Setting the run bit leaves the count bytes untouched.
// RQ6: Counts read back at any time with no side effect.
// RQ7: Software stops the timer before presetting counts.
// RQ8: Software stops the timer before changing mode.
// RQ9: Source 0 counts once per peripheral cycle of six peripheral clocks.
// RQ10: Source 1 counts a high sample followed by a low sample of the count pin.
// RQ11: Edge detection spans two peripheral cycles, so the rate is at most a twelfth.
// RQ12: External events hold each level at least one peripheral cycle.
// RQ13: A two-bit field picks one of four modes; mode 3 differs between timers.
// RQ14: With gate and run set, counting also needs the gating pin high.
// RQ15: Mode 0 counts 13 bits with a five-bit prescaler in the low byte.
// RQ16: Mode 2 counts the low byte and reloads it from the high byte on overflow.
// RQ17: Mode 3 splits timer 0; its high byte times with timer 1's run and flag.
//
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/10ps
`default_nettype none
module dtec_top
    import dtec_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // External pins
    input wire logic [1:0] count_pin,
    input wire logic [1:0] gating_input_pin,
    // Interrupt
    output logic irq
);
    // ********************************
    // State
    // ********************************
    // One packed struct, so reset and update stay in one place
    typedef struct packed {
        logic [1:0] cnt_s1;
        logic [1:0] cnt_s2;
        logic [1:0] gat_s1;
        logic [1:0] gat_s2;
        logic [1:0] smp;          // last per-cycle pin sample
        logic [1:0] run_bit;
        logic [1:0] overflow_flag;
        logic [7:0] mode;
        logic [1:0] imask;
        logic double_speed_mode;
        logic [7:0] hi0;
        logic [7:0] lo0;
        logic [7:0] hi1;
        logic [7:0] lo1;
        logic [31:0] rdata;
    } dtec_st_t;
    dtec_st_t s_r, s_nxt;
    logic tick;

    // Register decode shared by read and write paths
    function automatic logic [2:0] reg_sel(input logic [11:0] a);
        unique case (a)
            CTRL_OFS: reg_sel = 3'h1;
            MODE_OFS: reg_sel = 3'h2;
            CNT0_OFS: reg_sel = 3'h3;
            CNT1_OFS: reg_sel = 3'h4;
            IMSK_OFS: reg_sel = 3'h5;
            CFG_OFS: reg_sel = 3'h6;
            default: reg_sel = 3'h0;
        endcase
    endfunction : reg_sel

    // RQ9 peripheral cycle ticks
    dtec_cyc u_cyc (
        .pclk(pclk),
        .presetn(presetn),
        .double_speed_mode(s_r.double_speed_mode),
        .tick(tick)
    );

    // ********************************
    // Next state
    // ********************************
    // Helpers, each given a value in the process before it is read
    logic [1:0] inc;
    logic [1:0] src;
    logic [1:0] gate;
    logic [1:0] fall;
    logic [1:0] set_ovf;
    logic [1:0] md0, md1;
    logic hi0_inc;
    logic [8:0] s9;
    logic [2:0] sel;
    logic wr_acc;
    logic rd_setup;

    always_comb begin
        // Hold every field unless a branch below changes it
        s_nxt = s_r;
        set_ovf = 2'b00;
        // RQ13 two-bit mode per timer
        md0 = s_r.mode[MODE_LO +: 2];
        md1 = s_r.mode[TMR_STRIDE + MODE_LO +: 2];
        hi0_inc = 1'b0;
        s9 = 9'h000;
        sel = reg_sel(paddr);
        // Writes land in the access phase; reads are captured a cycle earlier
        wr_acc = psel && penable && pwrite;
        rd_setup = psel && !penable && !pwrite;
        // Pin synchronisers, two flops before any use
        s_nxt.cnt_s1 = count_pin;
        s_nxt.cnt_s2 = s_r.cnt_s1;
        s_nxt.gat_s1 = gating_input_pin;
        s_nxt.gat_s2 = s_r.gat_s1;
        // One pin sample per peripheral cycle; the edge test compares to it
        if (tick) begin
            s_nxt.smp = s_r.cnt_s2;
        end
        // RQ1 two independent timers
        for (int i = 0; i < 2; i++) begin
            src[i] = s_r.mode[i * TMR_STRIDE + SRC_BIT];
            gate[i] = s_r.mode[i * TMR_STRIDE + GATE_BIT];
            // RQ10 RQ11 high then low
            fall[i] = s_r.smp[i] && !s_r.cnt_s2[i];
            // RQ4 RQ14 run and gating
            inc[i] = tick && s_r.run_bit[i] && (!gate[i] || s_r.gat_s2[i])
                && (src[i] ? fall[i] : 1'b1);
        end
        // Timer 1 stalls in mode 3 (hold) or lends its run bit to timer 0
        if (md1 == DTEC_MSPLIT) begin
            inc[1] = 1'b0;
        end

        // ********************************
        // Timer 0 counting
        // ********************************
        if (inc[0]) begin
            unique case (dtec_mode_t'(md0))
                // RQ15 13-bit prescaled
                DTEC_M13: begin
                    // Upper three bits of the low byte just hold
                    s_nxt.lo0 = {s_r.lo0[7:5], s_r.lo0[4:0] + 5'h01};
                    if (s_r.lo0[4:0] == PRESC_MAX) begin
                        s9 = {1'b0, s_r.hi0} + 9'h001;
                        s_nxt.hi0 = s9[7:0];
                        set_ovf[0] = s9[8];
                    end
                end
                // RQ2 RQ3 16-bit cascade
                DTEC_M16: begin
                    s_nxt.lo0 = s_r.lo0 + 8'h01;
                    if (s_r.lo0 == 8'hFF) begin
                        s9 = {1'b0, s_r.hi0} + 9'h001;
                        s_nxt.hi0 = s9[7:0];
                        set_ovf[0] = s9[8];
                    end
                end
                // RQ16 auto-reload
                DTEC_M8R: begin
                    if (s_r.lo0 == 8'hFF) begin
                        s_nxt.lo0 = s_r.hi0;
                        set_ovf[0] = 1'b1;
                    end else begin
                        s_nxt.lo0 = s_r.lo0 + 8'h01;
                    end
                end
                // RQ17 low byte as 8-bit counter
                DTEC_MSPLIT: begin
                    s_nxt.lo0 = s_r.lo0 + 8'h01;
                    set_ovf[0] = (s_r.lo0 == 8'hFF);
                end
            endcase
        end
        // RQ17 high byte times on timer 1 run bit, sets timer 1 flag
        if (md0 == DTEC_MSPLIT) begin
            hi0_inc = tick && s_r.run_bit[1];
            if (hi0_inc) begin
                s_nxt.hi0 = s_r.hi0 + 8'h01;
                set_ovf[1] = (s_r.hi0 == 8'hFF);
            end
        end

        // ********************************
        // Timer 1 counting (mode 3 holds)
        // ********************************
        // Timer 1 still counts while timer 0 is split; the flag is then shared
        if (inc[1]) begin
            unique case (dtec_mode_t'(md1))
                // RQ15 13-bit prescaled
                DTEC_M13: begin
                    s_nxt.lo1 = {s_r.lo1[7:5], s_r.lo1[4:0] + 5'h01};
                    if (s_r.lo1[4:0] == PRESC_MAX) begin
                        s9 = {1'b0, s_r.hi1} + 9'h001;
                        s_nxt.hi1 = s9[7:0];
                        set_ovf[1] = set_ovf[1] | s9[8];
                    end
                end
                // RQ2 RQ3 16-bit cascade
                DTEC_M16: begin
                    s_nxt.lo1 = s_r.lo1 + 8'h01;
                    if (s_r.lo1 == 8'hFF) begin
                        s9 = {1'b0, s_r.hi1} + 9'h001;
                        s_nxt.hi1 = s9[7:0];
                        set_ovf[1] = set_ovf[1] | s9[8];
                    end
                end
                // RQ16 auto-reload
                DTEC_M8R: begin
                    if (s_r.lo1 == 8'hFF) begin
                        s_nxt.lo1 = s_r.hi1;
                        set_ovf[1] = 1'b1;
                    end else begin
                        s_nxt.lo1 = s_r.lo1 + 8'h01;
                    end
                end
                // RQ17 mode 3 holds the count
                DTEC_MSPLIT: begin
                    s_nxt.lo1 = s_r.lo1;
                end
            endcase
        end

        // ********************************
        // Register writes
        // ********************************
        // RQ5 run bit write touches no counts
        if (wr_acc) begin
            unique case (sel)
                3'h1: begin
                    s_nxt.run_bit = {pwdata[RUN1_BIT], pwdata[RUN0_BIT]};
                    s_nxt.overflow_flag = s_r.overflow_flag & ~{pwdata[OVF1_BIT], pwdata[OVF0_BIT]};
                end
                // RQ8 caller stops timer first
                3'h2: s_nxt.mode = pwdata[7:0];
                // RQ7 caller stops timer first
                3'h3: {s_nxt.hi0, s_nxt.lo0} = pwdata[15:0];
                3'h4: {s_nxt.hi1, s_nxt.lo1} = pwdata[15:0];
                3'h5: s_nxt.imask = pwdata[1:0];
                3'h6: s_nxt.double_speed_mode = pwdata[0];
                // Unmapped writes change nothing
                default: s_nxt.imask = s_r.imask;
            endcase
        end
        // RQ3 set wins over clear
        s_nxt.overflow_flag = s_nxt.overflow_flag | set_ovf;

        // Trade-off: a read shows the count one cycle before the access phase
        // RQ6 reads have no side effect, captured in setup
        if (rd_setup) begin
            s_nxt.rdata = 32'h0000_0000;
            unique case (sel)
                3'h1: begin
                    s_nxt.rdata[RUN0_BIT] = s_r.run_bit[0];
                    s_nxt.rdata[RUN1_BIT] = s_r.run_bit[1];
                    s_nxt.rdata[OVF0_BIT] = s_r.overflow_flag[0];
                    s_nxt.rdata[OVF1_BIT] = s_r.overflow_flag[1];
                end
                3'h2: s_nxt.rdata[7:0] = s_r.mode;
                3'h3: s_nxt.rdata[15:0] = {s_r.hi0, s_r.lo0};
                3'h4: s_nxt.rdata[15:0] = {s_r.hi1, s_r.lo1};
                3'h5: s_nxt.rdata[1:0] = s_r.imask;
                3'h6: s_nxt.rdata[0] = s_r.double_speed_mode;
                default: s_nxt.rdata = 32'h0000_0000;
            endcase
        end
    end

    // ********************************
    // Outputs
    // ********************************
    // Zero-wait slave; error on unmapped address
    assign pready = 1'b1;
    // Error shown only in the access phase
    assign pslverr = psel && penable && (reg_sel(paddr) == 3'h0);
    assign prdata = s_r.rdata;
    // RQ3 level request until cleared or masked
    assign irq = |(s_r.overflow_flag & s_r.imask);

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
            // Counts and mode start from their reset values
            s_r.mode <= MODE_RST;
            s_r.hi0 <= CNT_RST;
            s_r.lo0 <= CNT_RST;
            s_r.hi1 <= CNT_RST;
            s_r.lo1 <= CNT_RST;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule : dtec_top
`default_nettype wire

// >>> dtec_pkg.sv
// Constants and types for the dual timer/event counter block.
// Assumes a single 100 MHz pclk domain and an APB register slave.
package dtec_pkg;
    // ********************************
    // Register byte addresses
    // ********************************
    localparam logic [11:0] CTRL_OFS = 12'h000;  // run, overflow flags
    localparam logic [11:0] MODE_OFS = 12'h004;  // gate, source, mode per timer
    localparam logic [11:0] CNT0_OFS = 12'h008;  // timer 0 high:low
    localparam logic [11:0] CNT1_OFS = 12'h00C;  // timer 1 high:low
    localparam logic [11:0] IMSK_OFS = 12'h010;  // interrupt mask
    localparam logic [11:0] CFG_OFS = 12'h014;   // double speed select

    // ********************************
    // Field positions
    // ********************************
    localparam int RUN0_BIT = 0;
    localparam int RUN1_BIT = 1;
    localparam int OVF0_BIT = 4;
    localparam int OVF1_BIT = 5;
    localparam int MODE_LO = 0;   // two bits per timer, 4 bits apart
    localparam int SRC_BIT = 2;
    localparam int GATE_BIT = 3;
    localparam int TMR_STRIDE = 4;

    // ********************************
    // Reset values and timing
    // ********************************
    localparam logic [7:0] CNT_RST = 8'h00;
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam int PER_CYCLE_CLKS = 6;    // peripheral clocks per peripheral cycle
    localparam int OSC_DIV_STD = 2;       // pclk cycles per peripheral clock, standard
    localparam int OSC_DIV_X2 = 1;        // pclk cycles per peripheral clock, double speed
    localparam logic [3:0] PCYC_STD = 4'(PER_CYCLE_CLKS * OSC_DIV_STD);
    localparam logic [3:0] PCYC_X2 = 4'(PER_CYCLE_CLKS * OSC_DIV_X2);
    localparam logic [4:0] PRESC_MAX = 5'h1F;

    typedef enum logic [1:0] {
        DTEC_M13 = 2'h0,
        DTEC_M16 = 2'h1,
        DTEC_M8R = 2'h2,
        DTEC_MSPLIT = 2'h3
    } dtec_mode_t;
endpackage : dtec_pkg

// >>> dtec_cyc.sv
// Peripheral cycle tick generator.
// Assumes pclk stands in for the oscillator.
`timescale 1ns/10ps
`default_nettype none
module dtec_cyc
    import dtec_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic double_speed_mode,
    // Tick out
    output logic tick
);
    typedef struct packed {
        logic [3:0] cnt;
    } dtec_cyc_st_t;
    dtec_cyc_st_t s_r, s_nxt;
    logic [3:0] lim;

    // Period of one peripheral cycle
    always_comb begin
        lim = double_speed_mode ? PCYC_X2 : PCYC_STD;
        s_nxt = s_r;
        if (s_r.cnt >= lim - 4'h1) begin
            s_nxt.cnt = 4'h0;
        end else begin
            s_nxt.cnt = s_r.cnt + 4'h1;
        end
    end

    assign tick = (s_r.cnt == 4'h0);

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule : dtec_cyc
`default_nettype wire

// >>> dtec_chk.sv
// Port checker for the dual timer/event counter.
// Assumes it is bound to dtec_top on one pclk domain.
`timescale 1ns/10ps
`default_nettype none
module dtec_chk
    import dtec_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Pins and interrupt
    input wire logic [1:0] count_pin,
    input wire logic [1:0] gating_input_pin,
    input wire logic irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic acc, rd_a, wr_a;
    logic [1:0] run_r, msk_r, v_r;
    logic [7:0] md_r;
    logic [15:0] c0_r, c1_r;
    assign acc = psel && penable && pready;
    assign rd_a = acc && !pwrite;
    assign wr_a = acc && pwrite;
    // Shadows of the last software writes; v_r means written while stopped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_r <= 2'h0;
            msk_r <= 2'h0;
            md_r <= 8'h00;
            v_r <= 2'h3;
            c0_r <= 16'h0000;
            c1_r <= 16'h0000;
        end else if (wr_a) begin
            if (paddr == CTRL_OFS) run_r <= pwdata[1:0];
            if (paddr == CTRL_OFS && pwdata[1:0] != 2'h0) v_r <= 2'h0;
            if (paddr == MODE_OFS) md_r <= pwdata[7:0];
            if (paddr == IMSK_OFS) msk_r <= pwdata[1:0];
            if (paddr == CNT0_OFS) c0_r <= pwdata[15:0];
            if (paddr == CNT0_OFS) v_r[0] <= (run_r == 2'h0);
            if (paddr == CNT1_OFS) c1_r <= pwdata[15:0];
            if (paddr == CNT1_OFS) v_r[1] <= (run_r == 2'h0);
        end
    end
    property p_hold0;
        rd_a && paddr == CNT0_OFS && v_r[0] |-> prdata[15:0] == c0_r;
    endproperty
    a_hold0: assert property (p_hold0) else $error("count 0 moved while stopped");
    property p_hold1;
        rd_a && paddr == CNT1_OFS && v_r[1] |-> prdata[15:0] == c1_r;
    endproperty
    a_hold1: assert property (p_hold1) else $error("count 1 moved while stopped");
    property p_mode;
        rd_a && paddr == MODE_OFS |-> prdata[7:0] == md_r;
    endproperty
    a_mode: assert property (p_mode) else $error("mode readback wrong");
    property p_run;
        rd_a && paddr == CTRL_OFS |-> prdata[1:0] == $past(run_r, 1);
    endproperty
    a_run: assert property (p_run) else $error("run readback wrong");
    property p_irqm;
        msk_r == 2'h0 |-> !irq;
    endproperty
    a_irqm: assert property (p_irqm) else $error("irq while masked");
    property p_mskw;
        wr_a && paddr == IMSK_OFS && pwdata[1:0] == 2'h0 |=> !irq [*3];
    endproperty
    a_mskw: assert property (p_mskw) else $error("irq after mask cleared");
    property p_unmap;
        acc && paddr > CFG_OFS |-> pslverr && (pwrite || prdata == 32'h0);
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped access not refused");
    property p_rst;
        $rose(presetn) |-> prdata == 32'h0 && !irq && pready;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs not clear after reset");
    c_irq: cover property ($rose(irq));
    c_err: cover property (acc && pslverr);
    c_cnt: cover property (rd_a && paddr == CNT1_OFS && v_r[1]);
endmodule : dtec_chk
bind dtec_top dtec_chk chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .count_pin, .gating_input_pin, .irq);
`default_nettype wire

// >>> dtec_pins.sv
// Model of the external count and gating sources.
// Assumes the bench calls its tasks right after a pclk edge.
`timescale 1ns/10ps
`default_nettype none
module dtec_pins (
    // Clock
    input wire logic pclk,
    // Pins toward the block
    output logic [1:0] count_pin,
    output logic [1:0] gating_input_pin
);
    // Idle high so the first fall is a real edge
    initial begin
        count_pin = 2'h3;
        gating_input_pin = 2'h0;
    end
    task automatic edges(input int i, input int n);
        repeat (n) begin
            repeat (30) @(posedge pclk);
            count_pin[i] <= 1'b0;
            repeat (30) @(posedge pclk);
            count_pin[i] <= 1'b1;
        end
        repeat (30) @(posedge pclk);
    endtask : edges
    task automatic gate(input int i, input logic v);
        @(posedge pclk);
        gating_input_pin[i] <= v;
    endtask : gate
endmodule : dtec_pins
`default_nettype wire

// >>> dual_timer_event_counter_test.sv
// Bench: APB driver notes expected reads, a monitor compares them.
// Assumes dtec_top with dtec_chk bound and the dtec_pins model.
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin errors++; \
    $display("Error %s expected %h seen %h", n, e, s); end end
module dual_timer_event_counter_test
    import dtec_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, ev;
    logic [1:0] count_pin, gating_input_pin;
    int errors = 0;
    int n_checks = 0;
    logic [31:0] expq [$];
    realtime t0, t1, t2;
    logic [11:0] ofs [7] = '{CTRL_OFS, MODE_OFS, CNT0_OFS, CNT1_OFS, IMSK_OFS, CFG_OFS, 12'h020};
    logic [1:0] md [6] = '{2'h1, 2'h1, 2'h0, 2'h1, 2'h3, 2'h2};
    logic [15:0] pr [6] = '{16'h0040, 16'h00FF, 16'h00FF, 16'hFFFF, 16'h1234, 16'h80FF};
    logic [15:0] ex [6] = '{16'h0043, 16'h0100, 16'h01E0, 16'h0000, 16'h1236, 16'h8080};
    logic fl [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
    int nn [6] = '{3, 1, 1, 1, 2, 1};
    dtec_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .count_pin, .gating_input_pin, .irq);
    dtec_pins pins_u (.pclk, .count_pin, .gating_input_pin);
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // One transfer, with an idle cycle after so psel is never driven twice
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        expq.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask : rd
    task automatic rise(output realtime t);
        while (irq !== 1'b1) @(posedge pclk);
        t = $realtime;
    endtask : rise
    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test
    // Read monitor takes the oldest note at each read access
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite) begin
            ev = expq.pop_front();
            `CHK("prdata", ev, prdata)
        end
    end
    // Watchdog well past the expected run length
    initial begin
        repeat (40000) @(posedge pclk);
        errors++;
        end_of_test();
    end
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        void'($urandom(32'hF75D));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // Reset values, then an unmapped read
        foreach (ofs[k]) rd(ofs[k], 32'h0);
        pr[0][15:8] = 8'($urandom);
        ex[0][15:8] = pr[0][15:8];
        for (int i = 0; i < 2; i++) begin
            for (int k = 0; k < 6; k++) begin
                wr(MODE_OFS, 32'(4'h4 | md[k]) << (TMR_STRIDE * i));
                wr(i ? CNT1_OFS : CNT0_OFS, 32'(pr[k]));
                wr(CTRL_OFS, 32'h1 << i);
                rd(i ? CNT1_OFS : CNT0_OFS, 32'(pr[k]));
                pins_u.edges(i, nn[k]);
                wr(CTRL_OFS, 32'h0);
                rd(i ? CNT1_OFS : CNT0_OFS, 32'((i == 1 && md[k] == 2'h3) ? pr[k] : ex[k]));
                rd(CTRL_OFS, 32'(fl[k]) << (OVF0_BIT + i));
                wr(CTRL_OFS, 32'h30);
            end
        end
        // gating pin low blocks the first two edges
        wr(MODE_OFS, 32'hD);
        wr(CNT0_OFS, 32'h0);
        wr(CTRL_OFS, 32'h1);
        pins_u.edges(0, 2);
        pins_u.gate(0, 1'b1);
        pins_u.edges(0, 3);
        wr(CTRL_OFS, 32'h0);
        rd(CNT0_OFS, 32'h3);
        // reload every two ticks, both speeds
        wr(MODE_OFS, 32'h2);
        wr(CNT0_OFS, 32'hFEFE);
        wr(IMSK_OFS, 32'h1);
        for (int x = 0; x < 2; x++) begin
            wr(CFG_OFS, 32'(x));
            wr(CTRL_OFS, 32'h31);
            rise(t0);
            wr(CTRL_OFS, 32'h11);
            rise(t1);
            wr(CTRL_OFS, 32'h11);
            rise(t2);
            `CHK("period", 32'(2 * PER_CYCLE_CLKS * (x ? OSC_DIV_X2 : OSC_DIV_STD)), 32'(int'((t2 - t1) / 10.0)))
        end
        wr(IMSK_OFS, 32'h0);
        wr(CTRL_OFS, 32'h30);
        // split high byte runs on timer 1 run bit and flag
        wr(MODE_OFS, 32'h3);
        wr(CNT0_OFS, 32'hFF00);
        wr(CNT1_OFS, 32'h0);
        wr(IMSK_OFS, 32'h2);
        wr(CTRL_OFS, 32'h32);
        rise(t0);
        wr(CTRL_OFS, 32'h0);
        rd(CTRL_OFS, 32'h20);
        rd(CNT0_OFS, 32'h0);
        end_of_test();
    end
endmodule : dual_timer_event_counter_test
`default_nettype wire
